// File: dv/ewc_mem_model.sv
// Purpose: External device that pulls the wait pin during strobes
// Assumes: Wait pin has a pull-up on the board
// Notes: holdCycles of 0 leaves the pin released
`timescale 1ns/10ps
`default_nettype none

module ewc_mem_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic readStrobeN,
	input wire logic writeStrobeN,
	input wire logic [3:0] holdCycles,
	output wire logic extWaitN
);
	logic [3:0] lowCnt_reg;
	wire logic strobeLow = !(readStrobeN && writeStrobeN);

	// Pulled low for the first holdCycles of each strobe, pull-up otherwise
	assign extWaitN = !(strobeLow && lowCnt_reg < holdCycles);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lowCnt_reg <= 4'h0;
		end else if (!strobeLow) begin
			lowCnt_reg <= 4'h0;
		end else if (lowCnt_reg != 4'hf) begin
			lowCnt_reg <= lowCnt_reg + 4'h1;
		end
	end
endmodule // ewc_mem_model

`default_nettype wire

// File: dv/ewc_wait_monitor.sv
// Purpose: Port checker for the wait and idle controller
// Assumes: Bound to ewc_wait_ctrl from tb_top
// Notes: Bus and access timing as handed over by the designer
`timescale 1ns/10ps
`default_nettype none

module ewc_wait_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic reqValid,
	input wire logic [2:0] reqArea,
	input wire logic [4:0] areaSelectN,
	input wire logic readStrobeN,
	input wire logic writeStrobeN,
	input wire logic accessDone
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("register bus answer late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("register bus ack held");
	AST_RSVD_AREA4: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |->
		wb_dat_o[7:4] == 4'h0 && !wb_dat_o[13])
		else $error("reserved area 4 bits read nonzero");
	AST_RSVD_STROBE: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |->
		wb_dat_o[15:14] == 2'h0 && !wb_dat_o[10])
		else $error("reserved strobe bits read nonzero");
	AST_SEL_FROM_REQ: assert property ($fell(&areaSelectN) |->
		$past(reqValid) && areaSelectN == ~(5'h01 << $past(reqArea)))
		else $error("select does not follow request");
	AST_ONE_AREA: assert property ($onehot0(~areaSelectN))
		else $error("two areas selected");
	AST_STROBE_IN_SEL: assert property (!(readStrobeN && writeStrobeN) |->
		!(&areaSelectN) && (readStrobeN || writeStrobeN))
		else $error("strobe outside select");
	AST_DONE_AFTER_STROBE: assert property ($rose(readStrobeN & writeStrobeN) |->
		##[0:1] accessDone)
		else $error("done missing after strobe release");
	AST_DONE_PULSE: assert property (accessDone |=> !accessDone)
		else $error("done held");
endmodule // ewc_wait_monitor

`default_nettype wire

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the wait and idle controller
// Assumes: ewc_mem_model stands in for the external devices
// Notes: Lengths count core_clk cycles with a strobe low
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin numErrors++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [31:0] wbDatI = 32'h0;
	logic reqValid = 1'b0;
	logic [2:0] reqArea = 3'h0;
	logic reqWrite = 1'b0;
	logic [3:0] holdCycles = 4'h0;
	logic [15:0] q;
	wire logic [31:0] wbDatO;
	wire logic [4:0] selN;
	wire logic wbAck, extWaitN, rdN, wrN, accessDone;
	int numErrors = 0;
	int checks = 0;
	int sRun = 0;
	int hRun = 0;
	int lastLen = 0;
	int lastGap = 0;
	int uRun = 0;
	int lastSetup = 0;

	always #20 core_clk = ~core_clk;

	ewc_wait_ctrl i_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .reqValid(reqValid), .reqArea(reqArea),
		.reqWrite(reqWrite), .extWaitN(extWaitN), .areaSelectN(selN), .readStrobeN(rdN),
		.writeStrobeN(wrN), .accessDone(accessDone));
	ewc_mem_model i_mem (.core_clk(core_clk), .rst(rst), .readStrobeN(rdN),
		.writeStrobeN(wrN), .holdCycles(holdCycles), .extWaitN(extWaitN));

	// Strobe-low length and all-deselected gap, latched when each run ends
	always @(posedge core_clk) begin
		if (!(rdN && wrN)) begin
			sRun <= sRun + 1;
		end else if (sRun != 0) begin
			lastLen <= sRun;
			sRun <= 0;
		end
		if (&selN) begin
			hRun <= hRun + 1;
		end else if (hRun != 0) begin
			lastGap <= hRun;
			hRun <= 0;
		end
		// Select low with both strobes still high: the setup span
		if (!(&selN) && rdN && wrN) begin
			uRun <= uRun + 1;
		end else if (uRun != 0) begin
			lastSetup <= uRun;
			uRun <= 0;
		end
	end

	task wbXfer(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= {16'h0000, d};
		do @(posedge core_clk); while (wbAck !== 1'b1);
		q = wbDatO[15:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		wbXfer(a, 1'b1, d);
	endtask
	task rdChk(input logic [7:0] a, input logic [15:0] e);
		wbXfer(a, 1'b0, 16'h0000);
		`CHK("register", e, q)
	endtask
	task acc(input logic [2:0] a, input logic w);
		@(posedge core_clk);
		reqValid <= 1'b1;
		reqArea <= a;
		reqWrite <= w;
		do @(posedge core_clk); while (accessDone !== 1'b1);
		reqValid <= 1'b0;
	endtask
	// A floor check reports the floor itself once the floor is met
	task lenChk(input logic [2:0] a, input logic w, input int e, input logic floor);
		acc(a, w);
		repeat (2) @(posedge core_clk);
		`CHK("strobe length", e, (floor && lastLen > e) ? e : lastLen)
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task tReset();
		rdChk(8'h00, 16'haaff);
		rdChk(8'h04, 16'h000b);
		rdChk(8'h08, 16'h0000);
		rdChk(8'h1c, 16'h0000);
		wr(8'h04, 16'hffff);
		rdChk(8'h04, 16'hdf0f);
		wr(8'h08, 16'hffff);
		rdChk(8'h08, 16'h3bff);
		$display("registers done");
	endtask
	task tWaits();
		wr(8'h04, 16'h0000);
		wr(8'h08, 16'h0000);
		wr(8'h0c, 16'h7ff8);
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, 16'(c));
			lenChk(3'h0, 1'b0, (c == 3) ? 4 : c + 1, 1'b0);
		end
		wr(8'h00, 16'h0001);
		holdCycles <= 4'h6;
		lenChk(3'h0, 1'b0, 6, 1'b1);
		wr(8'h04, 16'h0100);
		lenChk(3'h0, 1'b0, 2, 1'b0);
		wr(8'h04, 16'h0000);
		wr(8'h00, 16'h0000);
		lenChk(3'h0, 1'b0, 1, 1'b0);
		holdCycles <= 4'h0;
		$display("waits done");
	endtask
	task tIdle();
		wr(8'h00, 16'h0300);
		acc(3'h0, 1'b0);
		acc(3'h1, 1'b0);
		`CHK("idle gap", 4, (lastGap > 4) ? 4 : lastGap)
		wr(8'h00, 16'h0c00);
		acc(3'h1, 1'b0);
		acc(3'h1, 1'b1);
		`CHK("idle gap", 4, (lastGap > 4) ? 4 : lastGap)
		$display("idle done");
	endtask
	task tDram();
		wr(8'h10, 16'h0004);
		for (int c = 0; c < 3; c++) begin
			wr(8'h00, 16'(c << 6));
			lenChk(3'h3, 1'b0, c + 1, 1'b0);
		end
		holdCycles <= 4'h6;
		wr(8'h00, 16'h0000);
		lenChk(3'h3, 1'b0, 1, 1'b0);
		wr(8'h00, 16'h0040);
		lenChk(3'h3, 1'b0, 6, 1'b1);
		wr(8'h04, 16'h0800);
		lenChk(3'h3, 1'b0, 2, 1'b0);
		wr(8'h10, 16'h0002);
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, 16'(c << 4));
			lenChk(3'h2, 1'b0, c + 1, 1'b0);
		end
		holdCycles <= 4'h0;
		$display("dram done");
	endtask
	task tArea4();
		wr(8'h10, 16'h0000);
		for (int r = 0; r < 3; r++) begin
			wr(8'h04, 16'(r << 14) | 16'h0001);
			lenChk(3'h4, 1'b1, (r == 2) ? 6 : r + 3, 1'b0);
		end
		wr(8'h08, 16'h1000);
		lenChk(3'h4, 1'b1, 6, 1'b0);
		`CHK("setup span", 3, lastSetup)
		$display("area4 done");
	endtask

	task report_and_stop();
		$display("checks %0d mismatches %0d", checks, numErrors);
		if (numErrors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		tReset();
		tWaits();
		tIdle();
		tDram();
		tArea4();
		report_and_stop();
	end
	initial begin
		#200000;
		numErrors++;
		report_and_stop();
	end
endmodule // tb_top

bind ewc_wait_ctrl ewc_wait_monitor i_mon (.core_clk(core_clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reqValid(reqValid), .reqArea(reqArea),
	.areaSelectN(areaSelectN), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
	.accessDone(accessDone));

`default_nettype wire

// File: rtl/ewc_area_decode.v
// Purpose: Turns the control fields of one area into cycle counts
// Assumes: area is 0 to 4; codes marked reserved are not written
// Notes: Purely combinational; the counters register the cycle counts, honourWait feeds the sequencer unregistered
`timescale 1ns/10ps
`default_nettype none
`include "ewc_defs.vh"

module ewc_area_decode (
	input wire [2:0] area,
	input wire [15:0] idleWaitCtl,
	input wire [15:0] area4Ctl,
	input wire [15:0] strobeCtl,
	input wire [15:0] longWaitSel,
	input wire [15:0] memType,
	output reg [3:0] waitCycles,
	output reg honourWait,
	output reg [2:0] idleCycles,
	output reg [2:0] setupCycles,
	output reg [2:0] releaseCycles
);

// ----------------------------------------------------------------
// Code tables
// ----------------------------------------------------------------
function [2:0] idleOf;
	input [1:0] code;
	begin
		idleOf = (code == 2'h3) ? 3'h4 : {1'b0, code};
	end
endfunction

// Long wait spans 3 to 14 cycles
function [3:0] longOf;
	input [2:0] code;
	begin
		case (code)
		3'h0, 3'h1, 3'h2, 3'h3: longOf = {1'b0, code} + 4'h3;
		3'h4: longOf = 4'h8;
		3'h5: longOf = 4'ha;
		3'h6: longOf = 4'hc;
		default: longOf = 4'he;
		endcase
	end
endfunction

reg [1:0] idleSel;
reg [1:0] waitSel;
reg [1:0] kind;
reg maskBit;

always @* begin
	if (area == `EWC_AREA4) begin
		idleSel = area4Ctl[`EWC_A4_IDLE_LSB +: 2];
		waitSel = area4Ctl[`EWC_A4_WAIT_LSB +: 2];
	end else begin
		idleSel = idleWaitCtl[`EWC_IDLE_LSB + {area[1:0], 1'b0} +: 2];
		waitSel = idleWaitCtl[`EWC_WAIT_LSB + {area[1:0], 1'b0} +: 2];
	end
	maskBit = area4Ctl[`EWC_MASK_LSB + area];
	if (area == 3'h2 && memType[1:0] == `EWC_MEM_SDRAM) begin
		kind = `EWC_MEM_SDRAM;
	end else if (area == 3'h3) begin
		kind = memType[3:2];
	end else begin
		kind = `EWC_MEM_ORDINARY;
	end
	idleCycles = idleOf(idleSel);
	case (kind)
	`EWC_MEM_SDRAM: begin
		waitCycles = {2'h0, waitSel};
		honourWait = 1'b0;
	end
	`EWC_MEM_DRAM: begin
		waitCycles = (waitSel == 2'h3) ? 4'h2 : {2'h0, waitSel};
		honourWait = ~maskBit & (waitSel != 2'h0);
	end
	default: begin
		if (waitSel == `EWC_WAIT_LONG) begin
			waitCycles = longOf(longWaitSel[3*area +: 3]);
		end else begin
			waitCycles = {2'h0, waitSel};
		end
		honourWait = ~maskBit & (waitSel != 2'h0);
	end
	endcase
	if (area == `EWC_AREA4) begin
		case (strobeCtl[`EWC_SETUP_LSB +: 3])
		3'h0: setupCycles = 3'h0;
		3'h1: setupCycles = 3'h1;
		3'h2: setupCycles = 3'h3;
		3'h3: setupCycles = 3'h5;
		default: setupCycles = 3'h7;
		endcase
		case (area4Ctl[`EWC_RELEASE_LSB +: 2])
		2'h0: releaseCycles = 3'h1;
		2'h1: releaseCycles = 3'h2;
		default: releaseCycles = 3'h4;
		endcase
		if (!honourWait) begin
			releaseCycles = 3'h0;
		end
	end else begin
		setupCycles = 3'h0;
		releaseCycles = 3'h0;
	end
end

endmodule // ewc_area_decode

`default_nettype wire

// File: rtl/ewc_defs.vh
// Purpose: Shared constants for the external wait and idle controller
// Assumes: Included by bare name from the decoder and controller design files of the block
// Notes: Offsets are byte addresses on a 32-bit classic Wishbone slave
`ifndef EWC_DEFS_VH
`define EWC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define EWC_OFS_IDLE_WAIT 8'h00
`define EWC_OFS_AREA4 8'h04
`define EWC_OFS_STROBE 8'h08
`define EWC_OFS_LONG_WAIT 8'h0c
`define EWC_OFS_MEM_TYPE 8'h10
`define EWC_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------
`define EWC_RST_IDLE_WAIT 16'haaff
`define EWC_RST_AREA4 16'h000b
`define EWC_RST_STROBE 16'h0000
`define EWC_RST_LONG_WAIT 16'h7fff
`define EWC_RST_MEM_TYPE 16'h0000
`define EWC_MSK_IDLE_WAIT 16'hffff
`define EWC_MSK_AREA4 16'hdf0f
`define EWC_MSK_STROBE 16'h3bff
`define EWC_MSK_LONG_WAIT 16'h7fff
`define EWC_MSK_MEM_TYPE 16'h000f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EWC_IDLE_LSB 8
`define EWC_WAIT_LSB 0
`define EWC_A4_WAIT_LSB 0
`define EWC_A4_IDLE_LSB 2
`define EWC_MASK_LSB 8
`define EWC_RELEASE_LSB 14
`define EWC_SETUP_LSB 11

// ----------------------------------------------------------------
// Memory types and special codes
// ----------------------------------------------------------------
`define EWC_MEM_ORDINARY 2'h0
`define EWC_MEM_DRAM 2'h1
`define EWC_MEM_SDRAM 2'h2
`define EWC_WAIT_LONG 2'h3
`define EWC_AREA4 3'h4

`endif

// File: rtl/ewc_down_counter.v
// Purpose: Loadable down counter that stops at zero
// Assumes: Single clock, asynchronous active-high reset
// Notes: zero is decoded from the held count, so it is glitch free
`timescale 1ns/10ps
`default_nettype none

module ewc_down_counter #(
	parameter WIDTH = 4
) (
	input wire core_clk,
	input wire rst,
	input wire load,
	input wire [WIDTH-1:0] loadValue,
	output wire zero
);

reg [WIDTH-1:0] count_reg;

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		count_reg <= {WIDTH{1'b0}};
	end else if (load) begin
		count_reg <= loadValue;
	end else if (count_reg != {WIDTH{1'b0}}) begin
		count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
	end
end

assign zero = (count_reg == {WIDTH{1'b0}});

endmodule // ewc_down_counter

`default_nettype wire

// File: rtl/ewc_wait_ctrl.v
// Purpose: Wait-state, idle-cycle and wait-mask control for five areas
// Assumes: Requests and the wait pin are synchronous to core_clk
// Notes: Registers are reached over a classic Wishbone slave
`timescale 1ns/10ps
`default_nettype none
`include "ewc_defs.vh"

module ewc_wait_ctrl (
	input wire core_clk,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire reqValid,
	input wire [2:0] reqArea,
	input wire reqWrite,
	input wire extWaitN,
	output wire [4:0] areaSelectN,
	output wire readStrobeN,
	output wire writeStrobeN,
	output wire accessDone
);

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_WAIT = 2'h2;
localparam ST_RELEASE = 2'h3;

// ----------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------
reg [15:0] idleWait_reg;
reg [15:0] area4_reg;
reg [15:0] strobe_reg;
reg [15:0] longWait_reg;
reg [15:0] memType_reg;
reg [31:0] rdData_reg;
reg ack_reg;

reg [1:0] state_reg;
reg [2:0] curArea_reg;
reg curWrite_reg;
reg [2:0] prevArea_reg;
reg prevWrite_reg;
reg [4:0] selectN_reg;
reg readStrobeN_reg;
reg writeStrobeN_reg;
reg done_reg;

wire wbReq = wb_cyc_i & wb_stb_i;
// Write lands on the edge at which the master sees ack high
wire wbWrite = wbReq & wb_we_i & ack_reg;

// Byte lanes 0 and 1 only; reserved bits are forced low here
function [15:0] wrMerge;
	input [15:0] old;
	input [31:0] dat;
	input [3:0] sel;
	input [15:0] mask;
	begin
		wrMerge = old;
		if (sel[0]) begin
			wrMerge[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			wrMerge[15:8] = dat[15:8];
		end
		wrMerge = wrMerge & mask;
	end
endfunction

// ----------------------------------------------------------------
// Wishbone slave
// ----------------------------------------------------------------
always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		ack_reg <= 1'b0;
	end else begin
		ack_reg <= wbReq & ~ack_reg;
	end
end

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		idleWait_reg <= `EWC_RST_IDLE_WAIT;
		area4_reg <= `EWC_RST_AREA4;
		strobe_reg <= `EWC_RST_STROBE;
		longWait_reg <= `EWC_RST_LONG_WAIT;
		memType_reg <= `EWC_RST_MEM_TYPE;
	end else if (wbWrite) begin
		case (wb_adr_i)
		`EWC_OFS_IDLE_WAIT: begin
			idleWait_reg <= wrMerge(idleWait_reg, wb_dat_i, wb_sel_i,
				`EWC_MSK_IDLE_WAIT);
		end
		`EWC_OFS_AREA4: begin
			area4_reg <= wrMerge(area4_reg, wb_dat_i, wb_sel_i,
				`EWC_MSK_AREA4);
		end
		`EWC_OFS_STROBE: begin
			strobe_reg <= wrMerge(strobe_reg, wb_dat_i, wb_sel_i,
				`EWC_MSK_STROBE);
		end
		`EWC_OFS_LONG_WAIT: begin
			longWait_reg <= wrMerge(longWait_reg, wb_dat_i, wb_sel_i,
				`EWC_MSK_LONG_WAIT);
		end
		`EWC_OFS_MEM_TYPE: begin
			memType_reg <= wrMerge(memType_reg, wb_dat_i, wb_sel_i,
				`EWC_MSK_MEM_TYPE);
		end
		default: begin
			idleWait_reg <= idleWait_reg;
		end
		endcase
	end
end

// Unmapped offsets still acknowledge and read as zero
always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		rdData_reg <= 32'h00000000;
	end else if (wbReq & ~ack_reg) begin
		case (wb_adr_i)
		`EWC_OFS_IDLE_WAIT: rdData_reg <= {16'h0000, idleWait_reg};
		`EWC_OFS_AREA4: rdData_reg <= {16'h0000, area4_reg};
		`EWC_OFS_STROBE: rdData_reg <= {16'h0000, strobe_reg};
		`EWC_OFS_LONG_WAIT: rdData_reg <= {16'h0000, longWait_reg};
		`EWC_OFS_MEM_TYPE: rdData_reg <= {16'h0000, memType_reg};
		`EWC_OFS_STATUS: begin
			rdData_reg <= {20'h00000, 3'h0, extWaitN, 1'b0, curArea_reg,
				2'h0, state_reg};
		end
		default: rdData_reg <= 32'h00000000;
		endcase
	end
end

assign wb_dat_o = rdData_reg;
assign wb_ack_o = ack_reg;

// ----------------------------------------------------------------
// Per-area settings
// ----------------------------------------------------------------
// In idle the decoder looks ahead at the request, so the first
// counter load already has the new area's settings.
wire [2:0] decArea = (state_reg == ST_IDLE) ? reqArea : curArea_reg;
wire [3:0] waitCycles;
wire honourWait;
wire [2:0] idleCycles;
wire [2:0] setupCycles;
wire [2:0] releaseCycles;

ewc_area_decode u_decode (
	.area(decArea),
	.idleWaitCtl(idleWait_reg),
	.area4Ctl(area4_reg),
	.strobeCtl(strobe_reg),
	.longWaitSel(longWait_reg),
	.memType(memType_reg),
	.waitCycles(waitCycles),
	.honourWait(honourWait),
	.idleCycles(idleCycles),
	.setupCycles(setupCycles),
	.releaseCycles(releaseCycles)
);

// ----------------------------------------------------------------
// Counters
// ----------------------------------------------------------------
reg phaseLoad;
reg [3:0] phaseValue;
reg gapLoad;
wire phaseZero;
wire gapZero;

ewc_down_counter #(
	.WIDTH(4)
) u_phase (
	.core_clk(core_clk),
	.rst(rst),
	.load(phaseLoad),
	.loadValue(phaseValue),
	.zero(phaseZero)
);

// Gap counter starts when the strobe ends and carries the
// finished area's idle count.
ewc_down_counter #(
	.WIDTH(3)
) u_gap (
	.core_clk(core_clk),
	.rst(rst),
	.load(gapLoad),
	.loadValue(idleCycles),
	.zero(gapZero)
);

// ----------------------------------------------------------------
// Access sequencer
// ----------------------------------------------------------------
wire areaChange = (reqArea != prevArea_reg);
wire readToWrite = ~prevWrite_reg & reqWrite;
wire needGap = areaChange | readToWrite;
// done_reg blocks a second take of a request still held high
wire start = reqValid & ~done_reg & (~needGap | gapZero);
wire waitHeld = honourWait & ~extWaitN;
wire waitOver = phaseZero & ~waitHeld;

reg [1:0] state_next;

// Setup and release load one less: the edge that leaves a phase is its last cycle
always @* begin
	state_next = state_reg;
	phaseLoad = 1'b0;
	phaseValue = 4'h0;
	gapLoad = 1'b0;
	case (state_reg)
	ST_IDLE: begin
		if (start) begin
			phaseLoad = 1'b1;
			if (setupCycles != 3'h0) begin
				phaseValue = {1'b0, setupCycles} - 4'h1;
				state_next = ST_SETUP;
			end else begin
				phaseValue = waitCycles;
				state_next = ST_WAIT;
			end
		end
	end
	ST_SETUP: begin
		if (phaseZero) begin
			phaseLoad = 1'b1;
			phaseValue = waitCycles;
			state_next = ST_WAIT;
		end
	end
	ST_WAIT: begin
		if (waitOver) begin
			if (releaseCycles != 3'h0) begin
				phaseLoad = 1'b1;
				phaseValue = {1'b0, releaseCycles} - 4'h1;
				state_next = ST_RELEASE;
			end else begin
				gapLoad = 1'b1;
				state_next = ST_IDLE;
			end
		end
	end
	ST_RELEASE: begin
		if (phaseZero) begin
			gapLoad = 1'b1;
			state_next = ST_IDLE;
		end
	end
	default: begin
		state_next = ST_IDLE;
	end
	endcase
end

wire strobeOn = (state_next == ST_WAIT) | (state_next == ST_RELEASE);
wire finishing = gapLoad;

always @(posedge core_clk or posedge rst) begin
	if (rst) begin
		state_reg <= ST_IDLE;
		curArea_reg <= 3'h0;
		curWrite_reg <= 1'b0;
		prevArea_reg <= 3'h0;
		prevWrite_reg <= 1'b1;
		selectN_reg <= 5'h1f;
		readStrobeN_reg <= 1'b1;
		writeStrobeN_reg <= 1'b1;
		done_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		done_reg <= finishing;
		if (state_reg == ST_IDLE && start) begin
			curArea_reg <= reqArea;
			curWrite_reg <= reqWrite;
			selectN_reg <= ~(5'h01 << reqArea);
		end else if (finishing) begin
			selectN_reg <= 5'h1f;
			prevArea_reg <= curArea_reg;
			prevWrite_reg <= curWrite_reg;
		end
		if (state_reg == ST_IDLE) begin
			readStrobeN_reg <= ~(strobeOn & ~reqWrite);
			writeStrobeN_reg <= ~(strobeOn & reqWrite);
		end else begin
			readStrobeN_reg <= ~(strobeOn & ~curWrite_reg);
			writeStrobeN_reg <= ~(strobeOn & curWrite_reg);
		end
	end
end

// ----------------------------------------------------------------
// Pins
// ----------------------------------------------------------------
assign areaSelectN = selectN_reg;
assign readStrobeN = readStrobeN_reg;
assign writeStrobeN = writeStrobeN_reg;
assign accessDone = done_reg;

endmodule // ewc_wait_ctrl

`default_nettype wire
